// ### rtl/orm_regs.sv
// Register slice: ROM image mapping, failed posted-write capture, maker id
// Contract
// - Quadlet ROM-window read: host address is ROM base plus offset low 10 bits.
// - ROM base is bits 31..10 of mapping register, read/write, resets to zero.
// - Mapping register bits 9..0 ignore writes and read as zero.
// - A failed posted write records its details in the two error registers.
// - Low error register takes the failed request's lower 32 offset bits.
// - High error register bits 31..16 take the requester bus and node number.
// - High error register bits 15..0 take the upper 16 offset bits.
// - Error registers are hardware-updated only, read-only to software.
// - Maker identifier is hard-wired read-only zero, writes ignored.
// - Error capture happens only while buffered write allow is one.
`timescale 1ns/1ps
`default_nettype none
module orm_regs
    import orm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    input  wire logic                      clk_en,
    input  wire logic                      soft_rst,
    // Avalon-MM slave
    input  wire logic [ORM_ADDR_W-1:0]     address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [ORM_DATA_W-1:0]     writedata,
    input  wire logic [ORM_BE_W-1:0]       byteenable,
    output logic [ORM_DATA_W-1:0]          readdata,
    output logic                           waitrequest,
    // ROM window read requests from remote nodes
    input  wire logic                      rom_rd_req,
    input  wire logic [ORM_OFFSET_W-1:0]   rom_rd_offset,
    output logic [ORM_DATA_W-1:0]          rom_host_addr,
    output logic                           rom_host_addr_valid,
    // Posted write failure reports
    input  wire logic                      post_fail,
    input  wire logic [ORM_SRC_W-1:0]      post_fail_src,
    input  wire logic [ORM_OFFSET_W-1:0]   post_fail_dest,
    // Control and interrupt
    output logic                           buffered_write_allow,
    output logic                           irq
);
    // Bus handshake state
    logic                      ack_r;
    logic                      ack_nxt;
    logic                      waitreq_r;
    logic [ORM_DATA_W-1:0]     readdata_r;
    logic [ORM_DATA_W-1:0]     readdata_nxt;

    // Software registers
    logic [ORM_ROM_BASE_W-1:0] rom_base_r;
    logic [ORM_ROM_BASE_W-1:0] rom_base_nxt;
    logic                      bwa_r;
    logic                      bwa_nxt;
    logic [ORM_INT_W-1:0]      int_stat_r;
    logic [ORM_INT_W-1:0]      int_stat_nxt;
    logic [ORM_INT_W-1:0]      int_mask_r;
    logic [ORM_INT_W-1:0]      int_mask_nxt;
    logic                      irq_r;

    // Sub-block results
    wire logic [ORM_DATA_W-1:0] fail_low;
    wire logic [ORM_DATA_W-1:0] fail_high;
    wire logic                  fail_captured;

    // Bus decode
    wire logic                  req;
    wire logic                  wr_fire;
    wire logic                  sel_rom;
    wire logic                  sel_low;
    wire logic                  sel_high;
    wire logic                  sel_maker;
    wire logic                  sel_ctrl;
    wire logic                  sel_stat;
    wire logic                  sel_mask;
    wire logic [ORM_DATA_W-1:0] be_mask;
    wire logic [ORM_DATA_W-1:0] rom_word;
    wire logic [ORM_DATA_W-1:0] rom_word_wr;
    wire logic [ORM_DATA_W-1:0] ctrl_word;
    wire logic [ORM_DATA_W-1:0] stat_word;
    wire logic [ORM_DATA_W-1:0] mask_word;
    wire logic [ORM_DATA_W-1:0] rd_mux;
    wire logic [ORM_INT_W-1:0]  int_events;
    wire logic [ORM_INT_W-1:0]  stat_clr;

    // Request handshake: one wait cycle, completes when waitrequest is low
    assign req     = read || write;
    assign wr_fire = write && ack_r;
    assign ack_nxt = req && !ack_r;

    // Address decode
    assign sel_rom   = (address == ORM_OFS_ROM_MAP);
    assign sel_low   = (address == ORM_OFS_FAIL_LOW);
    assign sel_high  = (address == ORM_OFS_FAIL_HIGH);
    assign sel_maker = (address == ORM_OFS_MAKER_ID);
    assign sel_ctrl  = (address == ORM_OFS_CTRL);
    assign sel_stat  = (address == ORM_OFS_INT_STAT);
    assign sel_mask  = (address == ORM_OFS_INT_MASK);

    // Byte lane mask
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};

    // Register read views
    assign rom_word  = {rom_base_r, {ORM_ROM_BASE_LSB{1'b0}}};
    assign ctrl_word = {{(ORM_DATA_W-ORM_CTRL_BWA_BIT-1){1'b0}}, bwa_r, {ORM_CTRL_BWA_BIT{1'b0}}};
    assign stat_word = {{(ORM_DATA_W-ORM_INT_W){1'b0}}, int_stat_r};
    assign mask_word = {{(ORM_DATA_W-ORM_INT_W){1'b0}}, int_mask_r};

    // Read mux; unmapped addresses read as zero
    assign rd_mux = sel_rom   ? rom_word :
                    sel_low   ? fail_low :
                    sel_high  ? fail_high :
                    sel_maker ? ORM_MAKER_ID_VAL :
                    sel_ctrl  ? ctrl_word :
                    sel_stat  ? stat_word :
                    sel_mask  ? mask_word :
                    ORM_WORD_RST;

    // Read data captured at the first edge, standing at the completing edge
    assign readdata_nxt = (read && !ack_r) ? rd_mux : readdata_r;

    // ROM base write: only bits 31..10 are stored
    assign rom_word_wr  = (rom_word & ~be_mask) | (writedata & be_mask);
    assign rom_base_nxt = (wr_fire && sel_rom) ? rom_word_wr[ORM_DATA_W-1:ORM_ROM_BASE_LSB]
                                               : rom_base_r;

    // Control register write
    assign bwa_nxt = (wr_fire && sel_ctrl && byteenable[ORM_CTRL_BWA_BIT/8])
                     ? writedata[ORM_CTRL_BWA_BIT] : bwa_r;

    // Interrupt events, sticky with write-one-to-clear; a set beats a clear
    assign int_events[ORM_INT_FAIL_BIT]  = fail_captured;
    assign int_events[ORM_INT_ROMRD_BIT] = rom_host_addr_valid;
    assign stat_clr     = (wr_fire && sel_stat && byteenable[0]) ? writedata[ORM_INT_W-1:0]
                                                                 : ORM_INT_RST;
    assign int_stat_nxt = (int_stat_r & ~stat_clr) | int_events;
    assign int_mask_nxt = (wr_fire && sel_mask && byteenable[0]) ? writedata[ORM_INT_W-1:0]
                                                                 : int_mask_r;

    // Failed-post and maker registers take no software writes

    // Bus handshake
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_r      <= 1'b0;
            waitreq_r  <= 1'b1;
            readdata_r <= ORM_WORD_RST;
        end else if (clk_en) begin
            ack_r      <= ack_nxt;
            waitreq_r  <= !ack_nxt;
            readdata_r <= readdata_nxt;
        end
    end

    // ROM base register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rom_base_r <= ORM_ROM_BASE_RST;
        end else if (clk_en) begin
            if (soft_rst) begin
                rom_base_r <= ORM_ROM_BASE_RST;
            end else begin
                rom_base_r <= rom_base_nxt;
            end
        end
    end

    // Control register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bwa_r <= ORM_CTRL_BWA_RST;
        end else if (clk_en) begin
            if (soft_rst) begin
                bwa_r <= ORM_CTRL_BWA_RST;
            end else begin
                bwa_r <= bwa_nxt;
            end
        end
    end

    // Interrupt status, mask and line
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            int_stat_r <= ORM_INT_RST;
            int_mask_r <= ORM_INT_RST;
            irq_r      <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                int_stat_r <= ORM_INT_RST;
                int_mask_r <= ORM_INT_RST;
                irq_r      <= 1'b0;
            end else begin
                int_stat_r <= int_stat_nxt;
                int_mask_r <= int_mask_nxt;
                irq_r      <= |(int_stat_nxt & int_mask_nxt);
            end
        end
    end

    // ROM window address former
    orm_rom_addr u_rom_addr (
        .clock           (clock),
        .arst_n          (arst_n),
        .clk_en          (clk_en),
        .soft_rst        (soft_rst),
        .rd_req          (rom_rd_req),
        .rd_offset       (rom_rd_offset),
        .rom_image_base  (rom_base_r),
        .host_addr       (rom_host_addr),
        .host_addr_valid (rom_host_addr_valid)
    );

    // Failed posted-write capture
    orm_err_capture u_err_capture (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .allow     (bwa_r),
        .fail      (post_fail),
        .fail_src  (post_fail_src),
        .fail_dest (post_fail_dest),
        .fail_low  (fail_low),
        .fail_high (fail_high),
        .captured  (fail_captured)
    );

    // Outputs
    assign readdata             = readdata_r;
    assign waitrequest          = waitreq_r;
    assign buffered_write_allow = bwa_r;
    assign irq                  = irq_r;
endmodule : orm_regs
`default_nettype wire

// ### rtl/orm_pkg.sv
// Shared constants for the ROM map and failed-post register slice
package orm_pkg;

    // Register byte offsets
    localparam logic [7:0] ORM_OFS_ROM_MAP    = 8'h34;
    localparam logic [7:0] ORM_OFS_FAIL_LOW   = 8'h38;
    localparam logic [7:0] ORM_OFS_FAIL_HIGH  = 8'h3c;
    localparam logic [7:0] ORM_OFS_MAKER_ID   = 8'h40;
    localparam logic [7:0] ORM_OFS_CTRL       = 8'h60;
    localparam logic [7:0] ORM_OFS_INT_STAT   = 8'h64;
    localparam logic [7:0] ORM_OFS_INT_MASK   = 8'h68;

    // Bus geometry
    localparam int ORM_ADDR_W = 8;
    localparam int ORM_DATA_W = 32;
    localparam int ORM_BE_W   = 4;

    // ROM mapping register layout
    localparam int ORM_ROM_BASE_LSB = 10;
    localparam int ORM_ROM_BASE_W   = 22;
    localparam logic [21:0] ORM_ROM_BASE_RST = 22'h000000;

    // ROM window: offset bits 47..10 must match this value
    localparam int ORM_OFFSET_W     = 48;
    localparam int ORM_WIN_LSB      = 10;
    localparam logic [37:0] ORM_ROM_WIN_TAG = 38'h3ffffc0001;

    // Failed-post high register layout
    localparam int ORM_SRC_LSB  = 16;
    localparam int ORM_SRC_W    = 16;
    localparam int ORM_OFSHI_W  = 16;

    // Control register layout
    localparam int ORM_CTRL_BWA_BIT   = 18;
    localparam logic ORM_CTRL_BWA_RST = 1'b0;

    // Interrupt status and mask layout
    localparam int ORM_INT_W          = 2;
    localparam int ORM_INT_FAIL_BIT   = 0;
    localparam int ORM_INT_ROMRD_BIT  = 1;
    localparam logic [1:0] ORM_INT_RST = 2'h0;

    // Maker identifier: no vendor-unique registers
    localparam logic [31:0] ORM_MAKER_ID_VAL = 32'h00000000;

    // Data reset for hardware-updated registers
    localparam logic [31:0] ORM_WORD_RST = 32'h00000000;

endpackage : orm_pkg

// ### rtl/orm_rom_addr.sv
// Forms host addresses for quadlet reads of the ROM window
`timescale 1ns/1ps
`default_nettype none
module orm_rom_addr
    import orm_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    input  wire logic                      clk_en,
    input  wire logic                      soft_rst,
    // Request
    input  wire logic                      rd_req,
    input  wire logic [ORM_OFFSET_W-1:0]   rd_offset,
    input  wire logic [ORM_ROM_BASE_W-1:0] rom_image_base,
    // Result
    output logic [ORM_DATA_W-1:0]          host_addr,
    output logic                           host_addr_valid
);
    wire logic                  in_window;
    wire logic [ORM_DATA_W-1:0] base_word;
    wire logic [ORM_DATA_W-1:0] addr_nxt;

    assign in_window = (rd_offset[ORM_OFFSET_W-1:ORM_WIN_LSB] == ORM_ROM_WIN_TAG);
    assign base_word = {rom_image_base, {ORM_ROM_BASE_LSB{1'b0}}};
    assign addr_nxt  = base_word + {{(ORM_DATA_W-ORM_WIN_LSB){1'b0}}, rd_offset[ORM_WIN_LSB-1:0]};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            host_addr       <= ORM_WORD_RST;
            host_addr_valid <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                host_addr_valid <= 1'b0;
            end else begin
                host_addr_valid <= rd_req && in_window;
                if (rd_req && in_window) begin
                    host_addr <= addr_nxt;
                end
            end
        end
    end
endmodule : orm_rom_addr
`default_nettype wire

// ### rtl/orm_err_capture.sv
// Captures source and destination of a failed posted write
`timescale 1ns/1ps
`default_nettype none
module orm_err_capture
    import orm_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    arst_n,
    input  wire logic                    clk_en,
    // Failure report
    input  wire logic                    allow,
    input  wire logic                    fail,
    input  wire logic [ORM_SRC_W-1:0]    fail_src,
    input  wire logic [ORM_OFFSET_W-1:0] fail_dest,
    // Captured words
    output logic [ORM_DATA_W-1:0]        fail_low,
    output logic [ORM_DATA_W-1:0]        fail_high,
    output logic                         captured
);
    wire logic take;

    assign take = fail && allow;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fail_low  <= ORM_WORD_RST;
            fail_high <= ORM_WORD_RST;
            captured  <= 1'b0;
        end else if (clk_en) begin
            captured <= take;
            if (take) begin
                fail_low  <= fail_dest[ORM_DATA_W-1:0];
                fail_high <= {fail_src, fail_dest[ORM_OFFSET_W-1:ORM_DATA_W]};
            end
        end
    end
endmodule : orm_err_capture
`default_nettype wire

// ### verif/orm_regs_chk.sv
// Concurrent checks on the ROM map and failed-post slice ports
`timescale 1ns/1ps
`default_nettype none
module orm_regs_chk
    import orm_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic        soft_rst,
    // Register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Remote side
    input wire logic        rom_rd_req,
    input wire logic [47:0] rom_rd_offset,
    input wire logic [31:0] rom_host_addr,
    input wire logic        rom_host_addr_valid,
    input wire logic        post_fail,
    input wire logic [15:0] post_fail_src,
    input wire logic [47:0] post_fail_dest,
    input wire logic        buffered_write_allow
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [31:0] low_r;
    logic [31:0] high_r;
    logic        cap_r;
    wire         in_win  = rom_rd_offset[47:10] == ORM_ROM_WIN_TAG;
    wire         rd_done = read && !waitrequest;
    // Shadow of the last accepted failure
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cap_r  <= 1'b0;
            low_r  <= 32'h0;
            high_r <= 32'h0;
        end else if (post_fail && clk_en && buffered_write_allow) begin
            cap_r  <= 1'b1;
            low_r  <= post_fail_dest[31:0];
            high_r <= {post_fail_src, post_fail_dest[47:32]};
        end
    end
    map_low_a: assert property (rom_rd_req && clk_en && !soft_rst && in_win |=>
        rom_host_addr_valid && rom_host_addr[9:0] == $past(rom_rd_offset[9:0]))
        else $error("rom host address wrong");
    no_window_a: assert property (rom_rd_req && !in_win |=> !rom_host_addr_valid)
        else $error("out of window read answered");
    low_zero_a: assert property (rd_done && address == ORM_OFS_ROM_MAP |-> readdata[9:0] == 10'h000)
        else $error("map low bits not zero");
    maker_a: assert property (rd_done && address == ORM_OFS_MAKER_ID |-> readdata == ORM_MAKER_ID_VAL)
        else $error("maker id wrong");
    low_cap_a: assert property (rd_done && cap_r && address == ORM_OFS_FAIL_LOW |-> readdata == low_r)
        else $error("fail low wrong");
    src_cap_a: assert property (rd_done && cap_r && address == ORM_OFS_FAIL_HIGH |->
        readdata[31:16] == high_r[31:16]) else $error("fail source wrong");
    ofs_hi_a: assert property (rd_done && cap_r && address == ORM_OFS_FAIL_HIGH |->
        readdata[15:0] == high_r[15:0]) else $error("fail high offset wrong");
    wait_one_a: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("wait low too long");
endmodule : orm_regs_chk
bind orm_regs orm_regs_chk u_chk (.clock, .arst_n, .clk_en, .soft_rst, .address, .read, .readdata,
    .waitrequest, .rom_rd_req, .rom_rd_offset, .rom_host_addr, .rom_host_addr_valid, .post_fail,
    .post_fail_src, .post_fail_dest, .buffered_write_allow);
`default_nettype wire

// ### verif/orm_node_model.sv
// Remote node model issuing ROM reads and failed posted writes
`timescale 1ns/1ps
`default_nettype none
module orm_node_model (
    // Clock
    input  wire logic       clock,
    // Requests
    output var logic        rom_rd_req,
    output var logic [47:0] rom_rd_offset,
    output var logic        post_fail,
    output var logic [15:0] post_fail_src,
    output var logic [47:0] post_fail_dest
);
    initial begin
        rom_rd_req = 1'b0;
        rom_rd_offset = 48'h0;
        post_fail = 1'b0;
        post_fail_src = 16'h0;
        post_fail_dest = 48'h0;
    end
    // One-cycle read; offset scrambled once released
    task automatic rom_read(input logic [47:0] ofs);
        @(posedge clock);
        rom_rd_req <= 1'b1;
        rom_rd_offset <= ofs;
        @(posedge clock);
        rom_rd_req <= 1'b0;
        rom_rd_offset <= ~ofs;
    endtask : rom_read
    // One-cycle failure report
    task automatic fail_report(input logic [15:0] src, input logic [47:0] dst);
        @(posedge clock);
        post_fail <= 1'b1;
        post_fail_src <= src;
        post_fail_dest <= dst;
        @(posedge clock);
        post_fail <= 1'b0;
        post_fail_src <= ~src;
        post_fail_dest <= ~dst;
    endtask : fail_report
endmodule : orm_node_model
`default_nettype wire

// ### verif/orm_regs_tb_top.sv
// Self-checking bench for the ROM map and failed-post slice
`timescale 1ns/1ps
`default_nettype none
module orm_regs_tb_top
    import orm_pkg::*;
;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        soft_rst = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rom_host_addr, rdat;
    logic        waitrequest, rom_host_addr_valid, buffered_write_allow, irq;
    logic        rom_rd_req, post_fail;
    logic [47:0] rom_rd_offset, post_fail_dest;
    logic [15:0] post_fail_src;
    logic [47:0] ofs [4] = '{48'hfffff0000400, 48'hfffff00007ff, 48'hfffff0000800, 48'hfffff00003ff};
    int          fail_count = 0;
    int          compares = 0;
    always #25 clock = ~clock;
    orm_node_model u_node (.clock, .rom_rd_req, .rom_rd_offset, .post_fail, .post_fail_src,
        .post_fail_dest);
    orm_regs u_dut (.clock, .arst_n, .clk_en, .soft_rst, .address, .read, .write,
        .writedata, .byteenable(4'hf), .readdata, .waitrequest, .rom_rd_req, .rom_rd_offset,
        .rom_host_addr, .rom_host_addr_valid, .post_fail, .post_fail_src, .post_fail_dest,
        .buffered_write_allow, .irq);
    task automatic finish_test();
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rdat = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk
    initial begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(ORM_OFS_ROM_MAP, 32'h0);
        bus(1'b1, ORM_OFS_ROM_MAP, 32'hffffffff);
        rd_chk(ORM_OFS_ROM_MAP, 32'hfffffc00);
        bus(1'b1, ORM_OFS_MAKER_ID, 32'hffffffff);
        rd_chk(ORM_OFS_MAKER_ID, ORM_MAKER_ID_VAL);
        rd_chk(8'h50, 32'h0);
        bus(1'b1, ORM_OFS_ROM_MAP, 32'h12345678);
        rd_chk(ORM_OFS_ROM_MAP, 32'h12345400);
        foreach (ofs[i]) begin
            u_node.rom_read(ofs[i]);
            @(posedge clock);
            chk({31'h0, rom_host_addr_valid}, {31'h0, i < 2});
            if (i < 2) chk(rom_host_addr, 32'h12345400 + {22'h0, ofs[i][9:0]});
        end
        rd_chk(ORM_OFS_INT_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, ORM_OFS_INT_MASK, 32'h3);
        rd_chk(ORM_OFS_INT_MASK, 32'h3);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ORM_OFS_INT_STAT, 32'h2);
        rd_chk(ORM_OFS_INT_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        u_node.fail_report(16'ha5c3, 48'h123489abcdef);
        rd_chk(ORM_OFS_INT_STAT, 32'h0);
        bus(1'b1, ORM_OFS_CTRL, 32'h00040000);
        rd_chk(ORM_OFS_CTRL, 32'h00040000);
        chk({31'h0, buffered_write_allow}, 32'h1);
        u_node.fail_report(16'ha5c3, 48'h123489abcdef);
        rd_chk(ORM_OFS_FAIL_LOW, 32'h89abcdef);
        rd_chk(ORM_OFS_FAIL_HIGH, 32'ha5c31234);
        rd_chk(ORM_OFS_INT_STAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ORM_OFS_FAIL_LOW, 32'hffffffff);
        bus(1'b1, ORM_OFS_FAIL_HIGH, 32'hffffffff);
        rd_chk(ORM_OFS_FAIL_HIGH, 32'ha5c31234);
        u_node.fail_report(16'h0102, 48'hfedc00000004);
        rd_chk(ORM_OFS_FAIL_HIGH, 32'h0102fedc);
        bus(1'b1, ORM_OFS_CTRL, 32'h0);
        u_node.fail_report(16'h7777, 48'h777777777777);
        rd_chk(ORM_OFS_FAIL_LOW, 32'h00000004);
        // Enable low freezes the address former
        @(posedge clock);
        clk_en <= 1'b0;
        u_node.rom_read(ofs[0]);
        @(posedge clock);
        chk({31'h0, rom_host_addr_valid}, 32'h0);
        clk_en <= 1'b1;
        // Soft reset clears the base but keeps captured words
        soft_rst <= 1'b1;
        @(posedge clock);
        soft_rst <= 1'b0;
        rd_chk(ORM_OFS_ROM_MAP, 32'h0);
        rd_chk(ORM_OFS_FAIL_LOW, 32'h00000004);
        chk({31'h0, irq}, 32'h0);
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        finish_test();
    end
endmodule : orm_regs_tb_top
`default_nettype wire
